// ---- common/tmr_map.svh ----
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// register indices within one timer page; byte address is four times
// the word index {page, index}
`define TMR_OFS_CTRL     8'hc8
`define TMR_OFS_CFG      8'hc9
`define TMR_OFS_RCAP_LO  8'hca
`define TMR_OFS_RCAP_HI  8'hcb
`define TMR_OFS_CNT_LO   8'hcc
`define TMR_OFS_CNT_HI   8'hcd
`define TMR_NUM_PAGES    2'h3
// control register fields
`define TMR_CTRL_TF      7
`define TMR_CTRL_EXF     6
`define TMR_CTRL_EXEN    3
`define TMR_CTRL_TR      2
`define TMR_CTRL_CT      1
`define TMR_CTRL_CPRL    0
// configuration register fields
`define TMR_CFG_M_HI     4
`define TMR_CFG_M_LO     3
`define TMR_CFG_TOG      2
`define TMR_CFG_TOE      1
`define TMR_CFG_DCEN     0
// values
`define TMR_RST_BYTE     8'h00
`define TMR_RST_WORD     16'h0000
`define TMR_CNT_MAX      16'hffff
`define TMR_CNT_STEP     16'h0001
`define TMR_DIV12_LAST   4'hb
`define TMR_EXT8_LAST    3'h7
`endif

// ---- common/tmr_pkg.sv ----
package tmr_pkg;
  // bus slave handshake states, one-hot
  typedef enum logic [1:0] {
    TMR_BUS_IDLE = 2'b01,
    TMR_BUS_ACK  = 2'b10
  } tmr_bus_state_t;
  // clock-select field encoding
  typedef enum logic [1:0] {
    TMR_CLK_DIV12 = 2'b00,
    TMR_CLK_SYS   = 2'b01,
    TMR_CLK_EXT8  = 2'b10,
    TMR_CLK_DIV2  = 2'b11
  } tmr_clk_sel_t;
endpackage

// ---- verilog/tmr_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_sync (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_fall
);
  logic meta;
  logic prev;

  // two-flop synchroniser, then a third flop for the falling edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta    <= 1'b0;
      o_level <= 1'b0;
      prev    <= 1'b0;
    end else begin
      meta    <= i_pin;
      o_level <= meta;
      prev    <= o_level;
    end
  end

  // at most one event per clock by construction
  assign o_fall = prev & ~o_level;
endmodule
`default_nettype wire

// ---- verilog/tmr_prescale.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_prescale (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_osc_pin_a,
  output logic      o_tick_div2,
  output logic      o_tick_div12,
  output logic      o_tick_ext8
);
  logic       osc_meta;
  logic       osc_sync;
  logic       osc_prev;
  logic       div2;
  logic [3:0] div12;
  logic [2:0] ext8;

  // external oscillator must stay below half the system clock to be seen
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= i_osc_pin_a;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // dividers give one-cycle enables, never derived clocks
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div2         <= 1'b0;
      div12        <= 4'h0;
      ext8         <= 3'h0;
      o_tick_div2  <= 1'b0;
      o_tick_div12 <= 1'b0;
      o_tick_ext8  <= 1'b0;
    end else begin
      div2         <= ~div2;
      div12        <= (div12 == `TMR_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      o_tick_div2  <= div2;
      o_tick_div12 <= (div12 == `TMR_DIV12_LAST);
      o_tick_ext8  <= 1'b0;
      if (osc_sync && !osc_prev) begin
        ext8        <= ext8 + 3'h1;
        o_tick_ext8 <= (ext8 == `TMR_EXT8_LAST);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tmr_timers.sv ----
// Contract
// - three 16-bit counts, low and high byte
// - source: system_clock, /2, /12, ext/8, pin falls
// - select 00 /12, 01 sys, 10 ext/8, 11 /2
// - counter select counts count pin falls
// - second and third timers share pins
// - decrement enable: trigger high up, low down
// - decrement enable: trigger sets direction only
// - capture mode trigger fall copies count
// - capture sets external flag, requests interrupt
// - capture mode overflow sets overflow flag
// - capture down: 0000 to ffff sets flag
// - captures only with external enable set
// - reload up overflow: flag, reload, continue
// - reload mode trigger fall forces reload
// - reload down match: flag, load ffff
// - reload mode when select clear, run starts
// - reload mode: external flag toggles, no interrupt
// - second, fourth timers toggle output pin
// - toggle bit reads and forces output level
// - overflow pulses to dac, baud; adc from second, third only
// - overflow flag stays set until software clears; reload wrap toggles external flag
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_timers
  import tmr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_osc_pin_a,
  input  wire logic        i_shared_count_pin,
  input  wire logic        i_shared_trigger_pin,
  input  wire logic        i_fourth_count_pin,
  input  wire logic        i_fourth_trigger_pin,
  output logic             o_second_toggle_pin,
  output logic             o_second_toggle_oe,
  output logic             o_fourth_toggle_pin,
  output logic             o_fourth_toggle_oe,
  output logic      [2:0]  o_timer_irq,
  output logic      [1:0]  o_adc_start,
  output logic      [2:0]  o_dac_update,
  output logic      [2:0]  o_uart0_baud
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  tmr_bus_state_t state;
  logic [15:0]    cnt       [3];
  logic [15:0]    rcap      [3];
  logic [15:0]    next_cnt  [3];
  logic [2:0]     tf, exf, exen, tr, ct, cprl, tog, toe, dcen;
  logic [1:0]     clk_sel   [3];
  logic [2:0]     tick, down, trig_evt, wrap, src_tick;
  logic [2:0]     wr_ctrl, wr_cfg, wr_rcap_lo, wr_rcap_hi, wr_cnt_lo, wr_cnt_hi;
  logic [2:0]     ovf_q;
  logic [2:0]     cnt_fall_v, trig_fall_v, trig_lvl_v;
  logic           tick_div2, tick_div12, tick_ext8;
  logic           shared_cnt_lvl, shared_cnt_fall;
  logic           fourth_cnt_lvl, fourth_cnt_fall;
  logic           shared_trig_lvl, shared_trig_fall;
  logic           fourth_trig_lvl, fourth_trig_fall;
  logic           wr_now;
  logic [7:0]     wdata;
  logic [1:0]     page;
  logic [7:0]     ofs;

  // register write strobe for one timer page and one index
  function automatic logic hit(input logic [1:0] pg, input logic [7:0] of,
                               input int unsigned idx, input logic [7:0] target);
    hit = (pg == idx[1:0]) && (of == target);
  endfunction

  // readback of one register; toggle bit exists on second and fourth only
  function automatic logic [7:0] rd_reg(input int unsigned i, input logic [7:0] of);
    logic [7:0] r;
    r = `TMR_RST_BYTE;
    case (of)
      `TMR_OFS_CTRL: begin
        r[`TMR_CTRL_TF]   = tf[i];
        r[`TMR_CTRL_EXF]  = exf[i];
        r[`TMR_CTRL_EXEN] = exen[i];
        r[`TMR_CTRL_TR]   = tr[i];
        r[`TMR_CTRL_CT]   = ct[i];
        r[`TMR_CTRL_CPRL] = cprl[i];
      end
      `TMR_OFS_CFG: begin
        r[`TMR_CFG_M_HI:`TMR_CFG_M_LO] = clk_sel[i];
        r[`TMR_CFG_TOG]  = tog[i];
        r[`TMR_CFG_TOE]  = toe[i];
        r[`TMR_CFG_DCEN] = dcen[i];
      end
      `TMR_OFS_RCAP_LO: r = rcap[i][7:0];
      `TMR_OFS_RCAP_HI: r = rcap[i][15:8];
      `TMR_OFS_CNT_LO:  r = cnt[i][7:0];
      `TMR_OFS_CNT_HI:  r = cnt[i][15:8];
      default:          r = `TMR_RST_BYTE;
    endcase
    rd_reg = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and prescaler
  tmr_pin_sync u_shared_cnt (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_shared_count_pin),
    .o_level   (shared_cnt_lvl),
    .o_fall    (shared_cnt_fall)
  );
  tmr_pin_sync u_shared_trig (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_shared_trigger_pin),
    .o_level   (shared_trig_lvl),
    .o_fall    (shared_trig_fall)
  );
  tmr_pin_sync u_fourth_cnt (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_fourth_count_pin),
    .o_level   (fourth_cnt_lvl),
    .o_fall    (fourth_cnt_fall)
  );
  tmr_pin_sync u_fourth_trig (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_fourth_trigger_pin),
    .o_level   (fourth_trig_lvl),
    .o_fall    (fourth_trig_fall)
  );
  tmr_prescale u_prescale (
    .i_ref_clk    (i_ref_clk),
    .i_reset_n    (i_reset_n),
    .i_osc_pin_a  (i_osc_pin_a),
    .o_tick_div2  (tick_div2),
    .o_tick_div12 (tick_div12),
    .o_tick_ext8  (tick_ext8)
  );

  // second and third timer see the same shared pins
  assign cnt_fall_v  = {fourth_cnt_fall, shared_cnt_fall, shared_cnt_fall};
  assign trig_fall_v = {fourth_trig_fall, shared_trig_fall, shared_trig_fall};
  assign trig_lvl_v  = {fourth_trig_lvl, shared_trig_lvl, shared_trig_lvl};

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops for one cycle, write lands on that edge
  assign wr_now = (state == TMR_BUS_ACK) && i_avs_write && i_avs_byteenable[0];
  assign wdata  = i_avs_writedata[7:0];
  assign page   = i_avs_address[9:8];
  assign ofs    = i_avs_address[7:0];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      wr_ctrl[i]    = wr_now && hit(page, ofs, i, `TMR_OFS_CTRL);
      wr_cfg[i]     = wr_now && hit(page, ofs, i, `TMR_OFS_CFG);
      wr_rcap_lo[i] = wr_now && hit(page, ofs, i, `TMR_OFS_RCAP_LO);
      wr_rcap_hi[i] = wr_now && hit(page, ofs, i, `TMR_OFS_RCAP_HI);
      wr_cnt_lo[i]  = wr_now && hit(page, ofs, i, `TMR_OFS_CNT_LO);
      wr_cnt_hi[i]  = wr_now && hit(page, ofs, i, `TMR_OFS_CNT_HI);
    end
  end

  // handshake; read data is a snapshot taken when the request is seen
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state             <= TMR_BUS_IDLE;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else begin
      case (state)
        TMR_BUS_IDLE: begin
          if (i_avs_read || i_avs_write) begin
            state             <= TMR_BUS_ACK;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= 32'h0000_0000;
            if (i_avs_read && page < `TMR_NUM_PAGES) begin
              o_avs_readdata[7:0] <= rd_reg(page, ofs);
            end
          end
        end
        TMR_BUS_ACK: begin
          state             <= TMR_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
        default: begin
          state             <= TMR_BUS_IDLE;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count events, direction, wrap detection and next count
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (clk_sel[i])
        TMR_CLK_DIV12: src_tick[i] = tick_div12;
        TMR_CLK_SYS:   src_tick[i] = 1'b1;
        TMR_CLK_EXT8:  src_tick[i] = tick_ext8;
        TMR_CLK_DIV2:  src_tick[i] = tick_div2;
        default:       src_tick[i] = 1'b0;
      endcase
      tick[i] = tr[i] && (ct[i] ? cnt_fall_v[i] : src_tick[i]);
      down[i] = dcen[i] && !trig_lvl_v[i];
      // trigger pin is direction only while decrement is on
      trig_evt[i] = tr[i] && exen[i] && !dcen[i] && trig_fall_v[i];
      if (cprl[i]) begin
        wrap[i] = tick[i] && (down[i] ? (cnt[i] == `TMR_RST_WORD)
                                      : (cnt[i] == `TMR_CNT_MAX));
      end else begin
        wrap[i] = tick[i] && (down[i] ? (cnt[i] == rcap[i])
                                      : (cnt[i] == `TMR_CNT_MAX));
      end
      next_cnt[i] = cnt[i];
      if (tick[i]) begin
        next_cnt[i] = down[i] ? cnt[i] - `TMR_CNT_STEP : cnt[i] + `TMR_CNT_STEP;
        if (wrap[i] && !cprl[i]) begin
          next_cnt[i] = down[i] ? `TMR_CNT_MAX : rcap[i];
        end
      end
      if (trig_evt[i] && !cprl[i]) begin
        next_cnt[i] = rcap[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count register; a software byte write beats the hardware step
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 3; i++) cnt[i] <= `TMR_RST_WORD;
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= next_cnt[i];
        if (wr_cnt_lo[i]) cnt[i][7:0] <= wdata;
        if (wr_cnt_hi[i]) cnt[i][15:8] <= wdata;
      end
    end
  end

  // capture/reload pair; a capture beats a software write
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 3; i++) rcap[i] <= `TMR_RST_WORD;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (trig_evt[i] && cprl[i]) begin
          rcap[i] <= cnt[i];
        end else begin
          if (wr_rcap_lo[i]) rcap[i][7:0] <= wdata;
          if (wr_rcap_hi[i]) rcap[i][15:8] <= wdata;
        end
      end
    end
  end

  // control bits and sticky flags; a hardware set wins over a clear
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tf   <= 3'h0;
      exf  <= 3'h0;
      exen <= 3'h0;
      tr   <= 3'h0;
      ct   <= 3'h0;
      cprl <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_ctrl[i]) begin
          tf[i]   <= wdata[`TMR_CTRL_TF];
          exf[i]  <= wdata[`TMR_CTRL_EXF];
          exen[i] <= wdata[`TMR_CTRL_EXEN];
          tr[i]   <= wdata[`TMR_CTRL_TR];
          ct[i]   <= wdata[`TMR_CTRL_CT];
          cprl[i] <= wdata[`TMR_CTRL_CPRL];
        end
        if (wrap[i]) tf[i] <= 1'b1;
        if (trig_evt[i]) begin
          exf[i] <= 1'b1;
        end else if (wrap[i] && !cprl[i]) begin
          // write and wrap together: the toggle applies to the old value
          exf[i] <= ~exf[i];
        end
      end
    end
  end

  // configuration bits; toggle state forced by a write, else flipped on wrap while toe is set
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 3; i++) clk_sel[i] <= TMR_CLK_DIV12;
      tog  <= 3'h0;
      toe  <= 3'h0;
      dcen <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_cfg[i]) begin
          clk_sel[i] <= wdata[`TMR_CFG_M_HI:`TMR_CFG_M_LO];
          toe[i]     <= wdata[`TMR_CFG_TOE];
          dcen[i]    <= wdata[`TMR_CFG_DCEN];
        end
        // the third timer has no toggle output, its bit stays zero
        if (i != 1) begin
          if (wr_cfg[i]) begin
            tog[i] <= wdata[`TMR_CFG_TOG];
          end else if (wrap[i] && toe[i]) begin
            tog[i] <= ~tog[i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: toggle pins, interrupt requests, overflow pulses
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_second_toggle_pin <= 1'b0;
      o_second_toggle_oe  <= 1'b0;
      o_fourth_toggle_pin <= 1'b0;
      o_fourth_toggle_oe  <= 1'b0;
      o_timer_irq         <= 3'h0;
      ovf_q               <= 3'h0;
    end else begin
      o_second_toggle_pin <= tog[0];
      o_second_toggle_oe  <= toe[0];
      o_fourth_toggle_pin <= tog[2];
      o_fourth_toggle_oe  <= toe[2];
      // external flag only interrupts in capture mode
      o_timer_irq         <= tf | (exf & cprl);
      ovf_q               <= wrap;
    end
  end

  // overflow pulses fan out to converter and baud logic
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_adc_start  <= 2'h0;
      o_dac_update <= 3'h0;
      o_uart0_baud <= 3'h0;
    end else begin
      o_adc_start  <= ovf_q[1:0];
      o_dac_update <= ovf_q;
      o_uart0_baud <= ovf_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the timers that the scenarios actually drive into each case
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  a_capture_copy: assert property (
    trig_evt[1] && cprl[1] |=> rcap[1] == $past(cnt[1]))
    else $error("capture did not copy the count");
  a_capture_flag: assert property (
    trig_evt[1] && cprl[1] |=> exf[1] ##1 o_timer_irq[1])
    else $error("capture did not raise external flag and request");
  a_dcen_no_trig: assert property (
    dcen[1] |-> !trig_evt[1])
    else $error("trigger acted while decrement enabled");
  a_flag_sticky: assert property (
    tf[0] && !wr_ctrl[0] |=> tf[0])
    else $error("overflow flag cleared by hardware");
  a_reload_up: assert property (
    tick[0] && !cprl[0] && !down[0] && cnt[0] == `TMR_CNT_MAX && !wr_cnt_lo[0] && !wr_cnt_hi[0]
    |=> cnt[0] == $past(rcap[0]) && tf[0])
    else $error("up overflow did not reload");
  a_reload_down: assert property (
    wrap[2] && !cprl[2] && down[2] && !wr_cnt_lo[2] && !wr_cnt_hi[2]
    |=> cnt[2] == `TMR_CNT_MAX)
    else $error("down match did not load all ones");
  a_capture_under: assert property (
    tick[1] && cprl[1] && down[1] && cnt[1] == `TMR_RST_WORD && !wr_ctrl[1]
    |=> tf[1])
    else $error("capture underflow did not set flag");
  a_exf_toggles: assert property (
    wrap[0] && !cprl[0] && !trig_evt[0] && !wr_ctrl[0] |=> exf[0] != $past(exf[0]))
    else $error("external flag did not toggle");
  a_stopped_holds: assert property (
    !tr[0] && !wr_cnt_lo[0] && !wr_cnt_hi[0] |=> cnt[0] == $past(cnt[0]))
    else $error("stopped timer moved");
  a_toggle_pin: assert property (
    wrap[0] && toe[0] && !wr_cfg[0] |-> ##2 o_second_toggle_pin != $past(o_second_toggle_pin))
    else $error("toggle pin did not flip");
  a_ovf_pulse: assert property (
    wrap[1] |-> ##2 o_adc_start[1] && o_dac_update[1] && o_uart0_baud[1])
    else $error("overflow pulse not delivered");
  a_ack_single: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
endmodule
`default_nettype wire

// ---- tb/tmr_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_cnt_go,
  input  wire logic i_trg_go,
  input  wire logic i_dir_up,
  output logic      o_cnt_pin,
  output logic      o_trg_pin,
  output var logic  o_osc
);
  logic [2:0] cnt_left;
  logic [2:0] trg_left;
  logic [1:0] osc_div;
  ////////////////////////////////////////////////////////////////////////
  // low pulses of four cycles; long enough for a two-flop synchroniser
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_left <= 3'h0;
      trg_left <= 3'h0;
    end else begin
      cnt_left <= i_cnt_go ? 3'h4 : (cnt_left != 3'h0 ? cnt_left - 3'h1 : 3'h0);
      trg_left <= i_trg_go ? 3'h4 : (trg_left != 3'h0 ? trg_left - 3'h1 : 3'h0);
    end
  end
  // pins idle high; trigger idles at the direction level
  assign o_cnt_pin = (cnt_left == 3'h0);
  assign o_trg_pin = i_dir_up & (trg_left == 3'h0);
  ////////////////////////////////////////////////////////////////////////
  // free-running oscillator, period six cycles, below half the clock
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_div <= 2'h0;
      o_osc   <= 1'b0;
    end else begin
      osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
      if (osc_div == 2'h2) o_osc <= ~o_osc;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_updown_timer_capture_reload.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_updown_timer_capture_reload;
  localparam logic [7:0] ix_ctl = `TMR_OFS_CTRL;
  localparam logic [7:0] ix_cfg = `TMR_OFS_CFG;
  localparam logic [7:0] ix_rl  = `TMR_OFS_RCAP_LO;
  localparam logic [7:0] ix_cl  = `TMR_OFS_CNT_LO;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  adr = 10'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdat;
  logic        wreq;
  logic [3:0]  go = 4'h0;
  logic [1:0]  dir = 2'b11;
  logic        cp1, tp1, cp2, tp2, osc;
  logic        tog2, oe2, tog4, oe4;
  logic [2:0]  irq, dac, baud;
  logic [1:0]  adc;
  logic [7:0]  seen = 8'h0;
  logic [7:0]  v8;
  logic [15:0] v16;
  int          fail_count = 0;
  int          n_tests = 0;
  ////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  // overflow pulses are one cycle wide, so collect them as they pass
  // outputs are unknown until reset has been applied, so skip those edges
  always @(posedge clk) if (rst_n) seen <= seen | {adc, dac, baud};
  tmr_timers uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_osc_pin_a(osc), .i_shared_count_pin(cp1), .i_shared_trigger_pin(tp1),
    .i_fourth_count_pin(cp2), .i_fourth_trigger_pin(tp2),
    .o_second_toggle_pin(tog2), .o_second_toggle_oe(oe2),
    .o_fourth_toggle_pin(tog4), .o_fourth_toggle_oe(oe4), .o_timer_irq(irq),
    .o_adc_start(adc), .o_dac_update(dac), .o_uart0_baud(baud));
  tmr_pin_model shared_pins (.i_ref_clk(clk), .i_reset_n(rst_n), .i_cnt_go(go[0]),
    .i_trg_go(go[1]), .i_dir_up(dir[0]), .o_cnt_pin(cp1), .o_trg_pin(tp1), .o_osc(osc));
  tmr_pin_model fourth_pins (.i_ref_clk(clk), .i_reset_n(rst_n), .i_cnt_go(go[2]),
    .i_trg_go(go[3]), .i_dir_up(dir[1]), .o_cnt_pin(cp2), .o_trg_pin(tp2), .o_osc());
  ////////////////////////////////////////////////////////////////////////
  // one bus transfer; request held until waitrequest is sampled low
  // a slave that never answers is left to the watchdog
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdat <= {24'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    v8 = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [1:0] p, input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {p, i}, d);
  endtask
  task automatic rreg(input logic [1:0] p, input logic [7:0] i);
    bus(1'b0, {p, i}, 8'h0);
  endtask
  task automatic rd16(input logic [1:0] p, input logic [7:0] i);
    rreg(p, i);
    v16[7:0] = v8;
    rreg(p, i + 8'h1);
    v16[15:8] = v8;
  endtask
  task automatic pin(input logic [3:0] m);
    @(posedge clk) go <= m;
    @(posedge clk) go <= 4'h0;
    repeat (12) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int p = 0; p < 3; p++)
      for (int i = 8'hc8; i <= 8'hcd; i++) begin
        rreg(p[1:0], i[7:0]);
        `CHK("reset_reg", 8'h00, v8)
      end
  endtask
  task automatic t_regs;
    wreg(1, ix_cl, 8'h5a);
    wreg(1, ix_cl + 8'h1, 8'ha5);
    wreg(1, ix_rl, 8'hc3);
    wreg(1, ix_rl + 8'h1, 8'h3c);
    be <= 4'h0;
    wreg(1, ix_cl, 8'hff);
    be <= 4'hf;
    rd16(1, ix_cl);
    `CHK("count", 16'ha55a, v16)
    rd16(1, ix_rl);
    `CHK("reload", 16'h3cc3, v16)
    rreg(3, ix_ctl);
    `CHK("unmapped", 8'h00, v8)
  endtask
  // elapsed run time is about 243 cycles; bounds allow prescaler phase
  task automatic t_clksel;
    logic [1:0]  sel [4] = '{2'b01, 2'b11, 2'b00, 2'b10};
    logic [15:0] lo [4] = '{16'd240, 16'd119, 16'd19, 16'd4};
    logic [15:0] hi [4] = '{16'd246, 16'd123, 16'd21, 16'd6};
    for (int k = 0; k < 4; k++) begin
      wreg(0, ix_cl, 8'h00);
      wreg(0, ix_cl + 8'h1, 8'h00);
      wreg(0, ix_cfg, {3'h0, sel[k], 3'h0});
      wreg(0, ix_ctl, 8'h04);
      repeat (240) @(posedge clk);
      wreg(0, ix_ctl, 8'h00);
      rd16(0, ix_cl);
      `CHK("clk_rate", 1'b1, (v16 >= lo[k] && v16 <= hi[k]))
    end
  endtask
  // /12 keeps the second wrap 192 cycles away, so exactly one is seen
  task automatic t_reload_up;
    wreg(0, ix_rl, 8'hf0);
    wreg(0, ix_rl + 8'h1, 8'hff);
    wreg(0, ix_cl, 8'hfe);
    wreg(0, ix_cl + 8'h1, 8'hff);
    wreg(0, ix_cfg, 8'h02);
    wreg(0, ix_ctl, 8'h04);
    repeat (30) @(posedge clk);
    rreg(0, ix_ctl);
    `CHK("ctl_wrap", 8'hc4, v8)
    `CHK("irq0", 1'b1, irq[0])
    rd16(0, ix_cl);
    `CHK("reloaded", 12'hfff, v16[15:4])
    rreg(0, ix_cfg);
    `CHK("tog_bit", 8'h06, v8)
    `CHK("tog_pin", 2'b11, {tog2, oe2})
    `CHK("pulses0", 8'h49, seen)
    wreg(0, ix_ctl, 8'h00);
    rreg(0, ix_ctl);
    `CHK("ctl_clear", 8'h00, v8)
    wreg(0, ix_cfg, 8'h02);
    repeat (2) @(posedge clk);
    `CHK("tog_force", 1'b0, tog2)
  endtask
  task automatic t_capture;
    wreg(1, ix_cl, 8'h34);
    wreg(1, ix_cl + 8'h1, 8'h12);
    wreg(1, ix_rl, 8'h00);
    wreg(1, ix_rl + 8'h1, 8'h00);
    wreg(1, ix_ctl, 8'h07);
    pin(4'h2);
    pin(4'h1);
    rd16(1, ix_rl);
    `CHK("no_capture", 16'h0000, v16)
    rd16(1, ix_cl);
    `CHK("pin_count", 16'h1235, v16)
    wreg(1, ix_ctl, 8'h0f);
    pin(4'h2);
    rd16(1, ix_rl);
    `CHK("captured", 16'h1235, v16)
    rreg(1, ix_ctl);
    `CHK("exf_cap", 8'h4f, v8)
    `CHK("irq1", 1'b1, irq[1])
    wreg(1, ix_ctl, 8'h0f);
    wreg(1, ix_cfg, 8'h01);
    dir[0] <= 1'b0;
    wreg(1, ix_cl, 8'h00);
    wreg(1, ix_cl + 8'h1, 8'h00);
    pin(4'h1);
    rd16(1, ix_cl);
    `CHK("underflow", 16'hffff, v16)
    rreg(1, ix_ctl);
    `CHK("ctl_down", 8'h8f, v8)
    rd16(1, ix_rl);
    `CHK("dir_only", 16'h1235, v16)
    dir[0] <= 1'b1;
    wreg(1, ix_ctl, 8'h0f);
    pin(4'h1);
    rd16(1, ix_cl);
    `CHK("overflow", 16'h0000, v16)
    rreg(1, ix_ctl);
    `CHK("ctl_up", 8'h8f, v8)
    wreg(1, ix_ctl, 8'h00);
  endtask
  task automatic t_fourth;
    wreg(2, ix_rl, 8'h05);
    wreg(2, ix_rl + 8'h1, 8'h00);
    wreg(2, ix_cl, 8'h00);
    wreg(2, ix_cl + 8'h1, 8'h01);
    wreg(2, ix_ctl, 8'h0e);
    pin(4'h8);
    rd16(2, ix_cl);
    `CHK("trig_reload", 16'h0005, v16)
    rreg(2, ix_ctl);
    `CHK("exf_reload", 8'h4e, v8)
    `CHK("irq2_exf", 1'b0, irq[2])
    wreg(2, ix_cfg, 8'h03);
    dir[1] <= 1'b0;
    wreg(2, ix_ctl, 8'h0e);
    pin(4'h4);
    rd16(2, ix_cl);
    `CHK("match_load", 16'hffff, v16)
    rreg(2, ix_ctl);
    `CHK("ctl_match", 8'hce, v8)
    `CHK("tog4", 2'b11, {tog4, oe4})
    `CHK("pulses", 8'hff, seen)
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // the whole sequence needs about 1400 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    `CHK("wreq_reset", 1'b1, wreq)
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_clksel();
    t_reload_up();
    t_capture();
    t_fourth();
    wrap_up();
  end
endmodule
`default_nettype wire
